// ### rtl/rxism_pkg.sv
// Package with register indices, field layout, reset values and carrier types.
package rxism_pkg;
   localparam int CHANNELS = 8;
   localparam int ADDR_W = 3;
   // Word indices of the registers; the byte address is four times the index.
   localparam logic [2:0] IDX_RAW = 3'h0;
   localparam logic [2:0] IDX_MASKED = 3'h1;
   localparam logic [2:0] IDX_SET = 3'h2;
   localparam logic [2:0] IDX_CLEAR = 3'h3;
   localparam logic [2:0] IDX_VECTOR = 3'h4;
   // Field positions inside each 32-bit word.
   localparam int PEND_LSB = 0;
   localparam int THRESH_LSB = 8;
   localparam int FIELD_MSB = 15;
   // Values after reset.
   localparam logic [7:0] RAW_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [31:0] READ_RESET = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   localparam logic [15:0] UPPER_ZERO = 16'h0000;
   // One bit per channel and source, laid out as the registers are.
   typedef struct packed {
      logic [CHANNELS-1:0] thresh;
      logic [CHANNELS-1:0] pend;
   } rxism_src_t;
   // Avalon request as one bundle.
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } rxism_req_t;
endpackage

// ### rtl/rxism_sticky.sv
// Bank of sticky pending flags, set by event pulses and cleared by software.
`timescale 1ns/1ns
`default_nettype none
module rxism_sticky #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] flags
);
   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= WIDTH'(rxism_pkg::RAW_RESET); // [RULE7]
      end else begin
         flags <= (flags & ~clr) | set;
      end
   end
endmodule
`default_nettype wire

// ### rtl/rxism_enable.sv
// Bank of interrupt enables with write-one-to-set and write-one-to-clear ports.
`timescale 1ns/1ns
`default_nettype none
module rxism_enable #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_set,
   input wire logic wr_clr,
   input wire logic [WIDTH-1:0] data,
   output logic [WIDTH-1:0] en
);
   // Zero bits in the written data leave their enables alone.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en <= WIDTH'(rxism_pkg::ENABLE_RESET); // [RULE7]
      end else if (wr_set) begin
         en <= en | data;
      end else if (wr_clr) begin
         en <= en & ~data;
      end
   end
endmodule
`default_nettype wire

// ### rtl/rxism_top.sv
// Receive interrupt status, masked status and enable registers on Avalon-MM.
//
// Function
// RULE1: The raw status word shows each channel's receive pending flag in bits 7..0, unmasked.
// RULE2: The raw status word shows each channel's threshold pending flag in bits 15..8, unmasked.
// RULE3: The masked status word shows a threshold flag in bits 15..8 only where it is enabled.
// RULE4: The masked status word shows a receive flag in bits 7..0 only where it is enabled.
// RULE5: Writing 1 to bit 8+n of the set register enables channel n's threshold interrupt.
// RULE6: Writing 1 to bit n of the set register enables channel n's receive interrupt.
// RULE7: After reset all pending flags and all enables are zero.
// RULE8: Writing 1 to a bit of the clear register disables that enable; a 0 does nothing.
// RULE9: The vector view shows the threshold flags in bits 15..8 with channel 0 at bit 8.
// RULE10: Bits 31..16 of the receive registers read zero and ignore writes.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rxism_top (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic [2:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [7:0] RX_PEND_EVT,
   input wire logic [7:0] RX_THRESH_EVT,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ
);

   rxism_pkg::rxism_req_t req;
   rxism_pkg::rxism_src_t raw;
   rxism_pkg::rxism_src_t en;
   rxism_pkg::rxism_src_t masked;
   rxism_pkg::rxism_src_t wr_bits;
   rxism_pkg::rxism_src_t raw_clr;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic irq_reg;
   logic first_reg;
   logic rd_cap;
   logic rd_acc;
   logic wr_acc;
   logic wr_set;
   logic wr_clr;
   logic [15:0] lane_mask;
   logic [31:0] rd_mux;

   // Bundle the bus request so that decode reads one carrier.
   assign req = {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE};

   // A request is captured while waitrequest is high and accepted one cycle later.
   assign rd_cap = req.read && wait_reg;
   assign rd_acc = req.read && !wait_reg;
   assign wr_acc = req.write && !wait_reg;

   // Only the two low byte lanes carry fields; upper lanes never reach storage.
   assign lane_mask = {{8{req.be[1]}}, {8{req.be[0]}}};
   assign wr_bits = req.wdata[15:0] & lane_mask; // [RULE10]

   // Writes take effect at the edge where the master sees waitrequest low.
   assign wr_set = wr_acc && (req.addr == rxism_pkg::IDX_SET);
   assign wr_clr = wr_acc && (req.addr == rxism_pkg::IDX_CLEAR);

   // Reading the raw word clears only the bits that were actually returned,
   // so an event landing between capture and acceptance stays pending.
   always_comb begin
      raw_clr = '0;
      if (rd_acc && (req.addr == rxism_pkg::IDX_RAW)) begin
         raw_clr = rdata_reg[15:0];
      end
   end

   // Receive pending flags of channels 7..0.
   rxism_sticky #(
      .WIDTH(rxism_pkg::CHANNELS)
   ) u_pend (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .set(RX_PEND_EVT),
      .clr(raw_clr.pend),
      .flags(raw.pend)
   );

   // Threshold pending flags of channels 7..0.
   rxism_sticky #(
      .WIDTH(rxism_pkg::CHANNELS)
   ) u_thresh (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .set(RX_THRESH_EVT),
      .clr(raw_clr.thresh),
      .flags(raw.thresh)
   );

   // Receive enables, set and cleared through their own words.
   rxism_enable #(
      .WIDTH(rxism_pkg::CHANNELS)
   ) u_en_pend (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .wr_set(wr_set), // [RULE6]
      .wr_clr(wr_clr), // [RULE8]
      .data(wr_bits.pend),
      .en(en.pend)
   );

   // Threshold enables, set and cleared through the same two words.
   rxism_enable #(
      .WIDTH(rxism_pkg::CHANNELS)
   ) u_en_thresh (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .wr_set(wr_set), // [RULE5]
      .wr_clr(wr_clr), // [RULE8]
      .data(wr_bits.thresh),
      .en(en.thresh)
   );

   // Masked view: a flag shows only where its enable is set.
   assign masked.thresh = raw.thresh & en.thresh; // [RULE3]
   assign masked.pend = raw.pend & en.pend; // [RULE4]

   // Read decode; the upper half of every word is forced to zero.
   always_comb begin
      rd_mux = rxism_pkg::UNMAPPED_DATA;
      case (req.addr)
         rxism_pkg::IDX_RAW: begin
            rd_mux = {rxism_pkg::UPPER_ZERO, raw}; // [RULE1] [RULE2] [RULE10]
         end
         rxism_pkg::IDX_MASKED: begin
            rd_mux = {rxism_pkg::UPPER_ZERO, masked}; // [RULE3] [RULE4]
         end
         rxism_pkg::IDX_SET: begin
            rd_mux = {rxism_pkg::UPPER_ZERO, en};
         end
         rxism_pkg::IDX_CLEAR: begin
            rd_mux = {rxism_pkg::UPPER_ZERO, en};
         end
         rxism_pkg::IDX_VECTOR: begin
            rd_mux = {rxism_pkg::UPPER_ZERO, raw}; // [RULE9]
         end
         default: begin
            rd_mux = rxism_pkg::UNMAPPED_DATA;
         end
      endcase
   end

   // One wait state for every access: low for exactly one cycle per request.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !((req.read || req.write) && wait_reg);
      end
   end

   // Read data is registered at capture and stands until the next capture.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_reg <= rxism_pkg::READ_RESET;
      end else if (rd_cap) begin
         rdata_reg <= rd_mux;
      end
   end

   // The interrupt line follows the masked view one cycle late, glitch free.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |masked;
      end
   end

   // Marks the first cycle after reset for the checks below.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   assign AVS_WAITREQUEST = wait_reg;
   assign AVS_READDATA = rdata_reg;
   assign IRQ = irq_reg;

   // Checks on the behaviour above.
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence s_capture(logic [2:0] idx);
      rd_cap && (req.addr == idx);
   endsequence

   sequence s_answer;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence

   property p_bus_one_wait;
      (req.read || req.write) && wait_reg |=> s_answer;
   endproperty
   a_bus_one_wait: assert property (p_bus_one_wait)
      else $error("waitrequest did not drop for exactly one cycle");

   property p_raw_pend;
      RX_PEND_EVT != 8'h00 |=> (raw.pend & $past(RX_PEND_EVT)) == $past(RX_PEND_EVT);
   endproperty
   a_raw_pend: assert property (p_raw_pend) // [RULE1]
      else $error("receive event did not set its raw flag");

   property p_raw_thresh;
      RX_THRESH_EVT != 8'h00 |=> (raw.thresh & $past(RX_THRESH_EVT)) == $past(RX_THRESH_EVT);
   endproperty
   a_raw_thresh: assert property (p_raw_thresh) // [RULE2]
      else $error("threshold event did not set its raw flag");

   property p_raw_read;
      s_capture(rxism_pkg::IDX_RAW) |=> AVS_READDATA[15:0] == $past(raw);
   endproperty
   a_raw_read: assert property (p_raw_read) // [RULE1]
      else $error("raw read returned wrong flags");

   property p_masked_thresh;
      s_capture(rxism_pkg::IDX_MASKED) |=>
         AVS_READDATA[15:8] == ($past(raw.thresh) & $past(en.thresh));
   endproperty
   a_masked_thresh: assert property (p_masked_thresh) // [RULE3]
      else $error("masked threshold field wrong");

   property p_masked_pend;
      s_capture(rxism_pkg::IDX_MASKED) |=>
         AVS_READDATA[7:0] == ($past(raw.pend) & $past(en.pend));
   endproperty
   a_masked_pend: assert property (p_masked_pend) // [RULE4]
      else $error("masked receive field wrong");

   property p_set_thresh;
      wr_set |=> en.thresh == ($past(en.thresh) | $past(wr_bits.thresh));
   endproperty
   a_set_thresh: assert property (p_set_thresh) // [RULE5]
      else $error("threshold enable set write misbehaved");

   property p_set_pend;
      wr_set |=> en.pend == ($past(en.pend) | $past(wr_bits.pend));
   endproperty
   a_set_pend: assert property (p_set_pend) // [RULE6]
      else $error("receive enable set write misbehaved");

   property p_reset_zero;
      first_reg |-> (raw == '0) && (en == '0) && !IRQ;
   endproperty
   a_reset_zero: assert property (p_reset_zero) // [RULE7]
      else $error("state not zero after reset");

   property p_clear;
      wr_clr |=> en == ($past(en) & ~$past(wr_bits));
   endproperty
   a_clear: assert property (p_clear) // [RULE8]
      else $error("enable clear write misbehaved");

   property p_vector;
      s_capture(rxism_pkg::IDX_VECTOR) |=> AVS_READDATA[15:8] == $past(raw.thresh);
   endproperty
   a_vector: assert property (p_vector) // [RULE9]
      else $error("vector view threshold field wrong");

   property p_upper_zero;
      rd_cap |=> AVS_READDATA[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) // [RULE10]
      else $error("upper half of a read not zero");

   property p_enable_hold;
      !wr_set && !wr_clr |=> en == $past(en);
   endproperty
   a_enable_hold: assert property (p_enable_hold) // [RULE8]
      else $error("enables changed without a write");

   property p_irq;
      ##1 IRQ == $past(|masked);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt line does not follow masked flags");

   // The raw read clears at acceptance, one edge after the data were captured.
   // An event sampled at that same edge must survive, so no interrupt is lost.
   sequence s_raw_accept;
      rd_acc && (req.addr == rxism_pkg::IDX_RAW);
   endsequence

   property p_read_clear;
      s_raw_accept |=> (raw & $past(rdata_reg[15:0])) ==
         ($past({RX_THRESH_EVT, RX_PEND_EVT}) & $past(rdata_reg[15:0]));
   endproperty
   a_read_clear: assert property (p_read_clear) // [RULE1]
      else $error("raw read cleared the wrong flags");

   property p_raw_hold;
      (RX_PEND_EVT == 8'h00) && (RX_THRESH_EVT == 8'h00) &&
         !(rd_acc && (req.addr == rxism_pkg::IDX_RAW)) |=> raw == $past(raw);
   endproperty
   a_raw_hold: assert property (p_raw_hold) // [RULE2]
      else $error("raw flags changed without an event or a raw read");

   property p_unmapped;
      rd_cap && (req.addr > rxism_pkg::IDX_VECTOR) |=>
         AVS_READDATA == rxism_pkg::UNMAPPED_DATA;
   endproperty
   a_unmapped: assert property (p_unmapped) // [RULE10]
      else $error("unmapped word did not read zero");

   property p_vector_pend;
      s_capture(rxism_pkg::IDX_VECTOR) |=> AVS_READDATA[7:0] == $past(raw.pend);
   endproperty
   a_vector_pend: assert property (p_vector_pend) // [RULE9]
      else $error("vector view receive field wrong");

   property p_irq_set;
      (|masked) |=> IRQ;
   endproperty
   a_irq_set: assert property (p_irq_set) // [RULE4]
      else $error("interrupt line low with an enabled flag pending");

   property p_irq_clear;
      !(|masked) |=> !IRQ;
   endproperty
   a_irq_clear: assert property (p_irq_clear) // [RULE3]
      else $error("interrupt line high with no enabled flag pending");

   property p_wait_idle;
      !(req.read || req.write) |=> AVS_WAITREQUEST;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("waitrequest dropped without a request");

   property p_read_stands;
      !rd_cap |=> AVS_READDATA == $past(AVS_READDATA);
   endproperty
   a_read_stands: assert property (p_read_stands)
      else $error("read data changed without a new capture");

   property p_accept_after_capture;
      rd_acc |-> $past(rd_cap);
   endproperty
   a_accept_after_capture: assert property (p_accept_after_capture)
      else $error("read accepted without a capture just before");

endmodule
`default_nettype wire

// ### verification/rxism_tb.sv
// Self-checking testbench for the receive interrupt status and enable block.
`timescale 1ns/1ns
`default_nettype none
module rxism_tb;
   logic ref_clk;
   logic reset_n;
   logic [2:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [7:0] pend_evt;
   logic [7:0] thr_evt;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   int n_errors = 0;
   int comparisons = 0;

   rxism_top rxism_top_i (
      .REF_CLK(ref_clk),
      .RESET_N(reset_n),
      .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read),
      .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(avs_byteenable),
      .RX_PEND_EVT(pend_evt),
      .RX_THRESH_EVT(thr_evt),
      .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest),
      .IRQ(irq)
   );

   // Free-running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Case inequality keeps an unknown from passing as a match.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access; the request is held until waitrequest is sampled low.
   task automatic bus(input logic rd, input logic [2:0] a, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_read <= rd;
      avs_write <= ~rd;
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rdat = avs_readdata;
      if (n >= 20) begin
         n_errors++;
         $display("[ERR] %0t no bus answer", $time);
         results();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [2:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      logic [31:0] dummy;
      bus(1'b0, a, d, be, dummy);
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b1, a, 32'h0000_0000, 4'hf, d);
      check(d, exp);
   endtask

   // Each event line is high for exactly one sampled edge.
   task automatic fire(input logic [7:0] p, input logic [7:0] t);
      @(posedge ref_clk);
      pend_evt <= p;
      thr_evt <= t;
      @(posedge ref_clk);
      pend_evt <= 8'h00;
      thr_evt <= 8'h00;
   endtask

   // The interrupt output is registered, so give it a few edges to settle.
   task automatic irq_chk(input logic exp);
      repeat (3) @(posedge ref_clk);
      check({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic t_reset;
      rd_chk(rxism_pkg::IDX_RAW, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_MASKED, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_SET, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_CLEAR, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_VECTOR, 32'h0000_0000);
      irq_chk(1'b0);
      $display("test reset done");
   endtask

   // Pending flags show in full while every source is disabled.
   task automatic t_raw_unmasked;
      fire(8'ha5, 8'h3c);
      rd_chk(rxism_pkg::IDX_VECTOR, 32'h0000_3ca5);
      rd_chk(rxism_pkg::IDX_MASKED, 32'h0000_0000);
      irq_chk(1'b0);
      rd_chk(rxism_pkg::IDX_RAW, 32'h0000_3ca5);
      rd_chk(rxism_pkg::IDX_RAW, 32'h0000_0000);
      $display("test raw done");
   endtask

   // Set and clear writes, including zeros and the reserved upper half.
   task automatic t_enables;
      wr(rxism_pkg::IDX_SET, 32'hffff_0f81);
      rd_chk(rxism_pkg::IDX_SET, 32'h0000_0f81);
      wr(rxism_pkg::IDX_SET, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_CLEAR, 32'h0000_0f81);
      fire(8'hff, 8'hff);
      rd_chk(rxism_pkg::IDX_MASKED, 32'h0000_0f81);
      irq_chk(1'b1);
      wr(rxism_pkg::IDX_CLEAR, 32'h0000_0f00);
      rd_chk(rxism_pkg::IDX_SET, 32'h0000_0081);
      wr(rxism_pkg::IDX_CLEAR, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_SET, 32'h0000_0081);
      rd_chk(rxism_pkg::IDX_MASKED, 32'h0000_0081);
      wr(rxism_pkg::IDX_CLEAR, 32'hffff_0081);
      irq_chk(1'b0);
      rd_chk(rxism_pkg::IDX_RAW, 32'h0000_ffff);
      $display("test enables done");
   endtask

   // Walk every channel so a swapped bit position shows up.
   task automatic t_channels;
      logic [7:0] p;
      logic [7:0] t;
      for (int n = 0; n < 8; n++) begin
         p = 8'h01 << n;
         t = 8'h80 >> n;
         fire(p, t);
         rd_chk(rxism_pkg::IDX_RAW, {16'h0000, t, p});
      end
      $display("test channels done");
   endtask

   // Lane gating, unmapped words, and a threshold-only mask.
   task automatic t_lanes;
      wr(rxism_pkg::IDX_SET, 32'h0000_ffff, 4'h2);
      rd_chk(rxism_pkg::IDX_SET, 32'h0000_ff00);
      wr(3'h5, 32'hffff_ffff);
      for (int a = 5; a < 8; a++) begin
         rd_chk(3'(a), 32'h0000_0000);
      end
      rd_chk(rxism_pkg::IDX_SET, 32'h0000_ff00);
      fire(8'h0f, 8'h0f);
      rd_chk(rxism_pkg::IDX_MASKED, 32'h0000_0f00);
      irq_chk(1'b1);
      rd_chk(rxism_pkg::IDX_RAW, 32'h0000_0f0f);
      irq_chk(1'b0);
      $display("test lanes done");
   endtask

   // An event sampled at the very edge that accepts a raw read must outlive the clear.
   task automatic t_race;
      fire(8'h01, 8'h00);
      fork
         rd_chk(rxism_pkg::IDX_RAW, 32'h0000_0001);
         begin
            @(posedge ref_clk);
            fire(8'h01, 8'h02);
         end
      join
      rd_chk(rxism_pkg::IDX_RAW, 32'h0000_0201);
      $display("test race done");
   endtask

   // A reset in mid-run must drop flags, enables and the interrupt line again.
   task automatic t_midreset;
      wr(rxism_pkg::IDX_SET, 32'h0000_ffff);
      fire(8'hff, 8'hff);
      irq_chk(1'b1);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      irq_chk(1'b0);
      rd_chk(rxism_pkg::IDX_VECTOR, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_SET, 32'h0000_0000);
      rd_chk(rxism_pkg::IDX_MASKED, 32'h0000_0000);
      $display("test mid-run reset done");
   endtask

   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence: every input has a value at time zero, reset for five edges.
   initial begin
      reset_n = 1'b0;
      avs_address = 3'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      pend_evt = 8'h00;
      thr_evt = 8'h00;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_raw_unmasked();
      t_enables();
      t_channels();
      t_lanes();
      t_race();
      t_midreset();
      results();
   end

   // The tests need well under two thousand cycles; this cuts a hang short.
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
   end
endmodule
`default_nettype wire
